/* logic/acp_pkg.sv */
// Constants and types shared by the converter control and output port
package acp_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int ACQ_NS = 1000;
  localparam int ACQ_CYC = (ACQ_NS * CLK_MHZ + 999) / 1000;
  localparam int STEP_NS = 400;
  localparam int STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [9:0] ACQ_LAST = 10'(ACQ_CYC - 1);
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYC - 1);
  // ==========================================================
  // Result word
  localparam int RES_W = 18;
  localparam logic [4:0] RES_MSB = 5'h11;
  localparam logic [4:0] RES_LSB = 5'h00;
  localparam logic [17:0] RES_MID = 18'h20000;
  // ==========================================================
  // Interface modes
  localparam logic [1:0] MODE_P18 = 2'h0;
  localparam logic [1:0] MODE_W16 = 2'h1;
  localparam logic [1:0] MODE_B8 = 2'h2;
  localparam logic [1:0] MODE_SER = 2'h3;
  // ==========================================================
  // Data line positions and enable masks
  localparam int LN_CODING = 0;
  localparam int LN_WORD = 1;
  localparam int LN_BYTE = 2;
  localparam int LN_SDO = 10;
  localparam int LN_SCLK = 11;
  localparam int LN_SYNC = 12;
  localparam logic [17:0] OE_ALL = 18'h3FFFF;
  localparam logic [17:0] OE_W16 = 18'h3FFFC;
  localparam logic [17:0] OE_B8 = 18'h3FC00;
  localparam logic [17:0] OE_SER_RD = 18'h03400;
  localparam logic [17:0] OE_SER_FIX = 18'h3C000;
  // ==========================================================
  // Synchroniser slots
  localparam int SYNC_W = 11;
  localparam int SI_CNV = 0;
  localparam int SI_CS = 1;
  localparam int SI_RD = 2;
  localparam int SI_PD = 3;
  localparam int SI_REF_BUFFER_DISABLE = 4;
  localparam int SI_MHI = 5;
  localparam int SI_MLO = 6;
  localparam int SI_COD = 7;
  localparam int SI_WORD = 8;
  localparam int SI_BYTE = 9;
  localparam int SI_SCLK = 10;
  localparam logic [10:0] SYNC_RST = 11'h007;
  // ==========================================================
  // Control states
  typedef enum logic [1:0] {
    ST_ACQ = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10,
    ST_PD = 2'b11
  } acp_state_t;
endpackage

/* logic/acp_sar.sv */
// Successive approximation engine paced by the internal conversion clock
`timescale 1ns/10ps
module acp_sar (
  input wire logic mclk,
  input wire logic rst,
  acp_sar_if.engine sar
);
  typedef struct packed {
    logic run;
    logic [7:0] cnt;
    logic [4:0] bitn;
    logic [17:0] code;
    logic done;
  } acp_sar_state_t;

  acp_sar_state_t s;
  acp_sar_state_t n;

  // ==========================================================
  // Bit trials, MSB first
  always_comb begin
    n = s;
    n.done = 1'b0;
    if (sar.start) begin
      n.run = 1'b1;
      n.cnt = '0;
      n.bitn = acp_pkg::RES_MSB;
      n.code = acp_pkg::RES_MID;
    end else if (s.run) begin
      if (s.cnt == acp_pkg::STEP_LAST) begin
        n.cnt = '0;
        if (!sar.comp) begin
          n.code[s.bitn] = 1'b0;
        end
        if (s.bitn == acp_pkg::RES_LSB) begin
          n.run = 1'b0;
          n.done = 1'b1;
        end else begin
          n.bitn = s.bitn - 5'h01;
          n.code[s.bitn - 5'h01] = 1'b1;
        end
      end else begin
        n.cnt = s.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign sar.done = s.done;
  assign sar.result = s.code;
  assign sar.trial = s.code;
endmodule

/* logic/acp_sar_if.sv */
// Link between the control logic and the successive approximation engine
`timescale 1ns/10ps
interface acp_sar_if;
  logic start;
  logic comp;
  logic done;
  logic [17:0] result;
  logic [17:0] trial;
  modport engine (input start, input comp, output done, output result, output trial);
  modport ctrl (output start, output comp, input done, input result, input trial);
endinterface

/* logic/acp_top.sv */
// Conversion control and result output port of the converter
// ==========================================================
// Summary of operation
// - Busy rises when a conversion starts and stays high until the result sits in the shift register.
// - The result bus is driven only while chip select and read are both low, except lines 14-17 in serial mode.
// - Chip select gates the external serial clock, so its edges are ignored while chip select is high.
// - A high reset returns everything to its reset state and abandons any running conversion.
// - Power-down lets a running conversion finish, then blocks new starts and enters low power.
// - If convert-start is high when acquisition ends, the next falling edge holds the sample and starts.
// - If convert-start is already low when acquisition ends, hold and conversion start at once.
// - The reference buffer is on while its disable input is low and off while it is high.
// - The two interface-select inputs give 18-bit, 16-bit, 8-bit or serial presentation.
// - In 18-bit mode every result bit drives the data line of the same index.
// - Lines 10-13 carry result bits except in serial mode, where they become the serial port lines.
// - Lines 14-17 stay outputs in serial mode; in the parallel modes they are outputs only while chip select and read are both low.
`timescale 1ns/10ps
module acp_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic convert_start_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic power_down_in,
  input wire logic ref_buffer_disable,
  input wire logic iface_select_hi,
  input wire logic iface_select_lo,
  input wire logic [17:0] data_in,
  input wire logic comp_in,
  output logic [17:0] data_out,
  output logic [17:0] data_oe,
  output logic busy,
  output logic sample_hold,
  output logic ref_buffer_en,
  output logic low_power,
  output logic [17:0] dac_code
);
  typedef struct packed {
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [10:0] sync3;
    logic [10:0] filt;
    acp_pkg::acp_state_t st;
    logic [9:0] acq_cnt;
    logic busy;
    logic hold;
    logic start;
    logic cnv_prev;
    logic sclk_prev;
    logic [17:0] result;
    logic [17:0] shreg;
    logic [17:0] dout;
    logic [17:0] doe;
    logic refbuf;
    logic lowpwr;
  } acp_top_state_t;

  acp_top_state_t s;
  acp_top_state_t n;
  acp_sar_if sar ();
  logic [10:0] raw;
  logic [1:0] mode;
  logic rd_en;
  logic [17:0] cres;

  acp_sar u_sar (
    .mclk(mclk),
    .rst(rst),
    .sar(sar.engine)
  );

  // ==========================================================
  // Pin inputs and decoded controls
  assign raw = {data_in[acp_pkg::LN_SCLK], data_in[acp_pkg::LN_BYTE], data_in[acp_pkg::LN_WORD],
                data_in[acp_pkg::LN_CODING], iface_select_lo, iface_select_hi, ref_buffer_disable,
                power_down_in, rd_n, cs_n, convert_start_n};
  assign mode = {s.filt[acp_pkg::SI_MHI], s.filt[acp_pkg::SI_MLO]};
  assign rd_en = !s.filt[acp_pkg::SI_CS] && !s.filt[acp_pkg::SI_RD];
  assign cres = s.filt[acp_pkg::SI_COD] ? s.result : (s.result ^ acp_pkg::RES_MID);
  assign sar.start = s.start;
  assign sar.comp = comp_in;

  // ==========================================================
  // Next state
  always_comb begin
    logic go;
    logic cnv_n;
    logic pd;
    logic sclk;
    go = 1'b0;
    cnv_n = s.filt[acp_pkg::SI_CNV];
    pd = s.filt[acp_pkg::SI_PD];
    sclk = s.filt[acp_pkg::SI_SCLK];
    n = s;
    n.start = 1'b0;
    n.sync1 = raw;
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    n.filt = (s.sync2 & s.sync3) | (s.filt & (s.sync2 | s.sync3));
    n.cnv_prev = cnv_n;
    n.sclk_prev = sclk;
    // Serial shift on the falling clock edge, only while selected
    if (mode == acp_pkg::MODE_SER && !s.filt[acp_pkg::SI_CS] && s.sclk_prev && !sclk) begin
      n.shreg = {s.shreg[16:0], 1'b0};
    end
    case (s.st)
      acp_pkg::ST_ACQ: begin
        if (s.acq_cnt == acp_pkg::ACQ_LAST) begin
          n.acq_cnt = '0;
          if (pd) begin
            n.st = acp_pkg::ST_PD;
          end else if (!cnv_n) begin
            go = 1'b1;
          end else begin
            n.st = acp_pkg::ST_WAIT;
          end
        end else begin
          n.acq_cnt = s.acq_cnt + 10'h001;
        end
      end
      acp_pkg::ST_WAIT: begin
        if (pd) begin
          n.st = acp_pkg::ST_PD;
        end else if (s.cnv_prev && !cnv_n) begin
          go = 1'b1;
        end
      end
      acp_pkg::ST_CONV: begin
        // Power-down is not checked here so a running conversion completes
        if (sar.done) begin
          n.result = sar.result;
          n.shreg = s.filt[acp_pkg::SI_COD] ? sar.result : (sar.result ^ acp_pkg::RES_MID);
          n.busy = 1'b0;
          n.hold = 1'b0;
          n.st = acp_pkg::ST_ACQ;
        end
      end
      acp_pkg::ST_PD: begin
        if (!pd) begin
          n.st = acp_pkg::ST_ACQ;
        end
      end
      default: begin
        n.st = acp_pkg::ST_ACQ;
      end
    endcase
    if (go) begin
      n.st = acp_pkg::ST_CONV;
      n.busy = 1'b1;
      n.hold = 1'b1;
      n.start = 1'b1;
    end
    n.lowpwr = (n.st == acp_pkg::ST_PD);
    n.refbuf = !s.filt[acp_pkg::SI_REF_BUFFER_DISABLE];
    // Output bus presentation per mode
    case (mode)
      acp_pkg::MODE_P18: begin
        n.dout = s.result;
        n.doe = rd_en ? acp_pkg::OE_ALL : '0;
      end
      acp_pkg::MODE_W16: begin
        n.doe = rd_en ? acp_pkg::OE_W16 : '0;
        if (s.filt[acp_pkg::SI_WORD]) begin
          n.dout = {14'h0000, cres[1:0], 2'h0};
        end else begin
          n.dout = {cres[17:2], 2'h0};
        end
      end
      acp_pkg::MODE_B8: begin
        n.doe = rd_en ? acp_pkg::OE_B8 : '0;
        case ({s.filt[acp_pkg::SI_WORD], s.filt[acp_pkg::SI_BYTE]})
          2'b00: begin
            n.dout = {cres[17:10], 10'h000};
          end
          2'b01: begin
            n.dout = {cres[9:2], 10'h000};
          end
          default: begin
            n.dout = {6'h00, cres[1:0], 10'h000};
          end
        endcase
      end
      default: begin
        // Serial: data on line 10, sclk input on 11, frame sync on 12, error flag low on 13
        n.doe = acp_pkg::OE_SER_FIX | (rd_en ? acp_pkg::OE_SER_RD : '0);
        n.dout = {5'h00, rd_en, 1'b0, s.shreg[17], 10'h000};
      end
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.sync1 <= acp_pkg::SYNC_RST;
      s.sync2 <= acp_pkg::SYNC_RST;
      s.sync3 <= acp_pkg::SYNC_RST;
      s.filt <= acp_pkg::SYNC_RST;
      s.cnv_prev <= 1'b1;
      s.refbuf <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign data_out = s.dout;
  assign data_oe = s.doe;
  assign busy = s.busy;
  assign sample_hold = s.hold;
  assign ref_buffer_en = s.refbuf;
  assign low_power = s.lowpwr;
  assign dac_code = sar.trial;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_busy_fall;
    $fell(s.busy) |-> $past(sar.done) && s.st == acp_pkg::ST_ACQ;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy fell without a finished conversion");

  property p_conv_busy;
    s.st == acp_pkg::ST_CONV |-> s.busy && s.hold;
  endproperty
  a_conv_busy: assert property (p_conv_busy) else $error("busy or hold low during conversion");

  property p_read_gate;
    (mode != acp_pkg::MODE_SER) && $stable(mode) && (s.doe != '0) |-> $past(rd_en);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("parallel bus driven without read");

  property p_sclk_gate;
    s.st != acp_pkg::ST_CONV && $past(s.st) != acp_pkg::ST_CONV && s.shreg != $past(s.shreg)
      |-> $past(!s.filt[acp_pkg::SI_CS]);
  endproperty
  a_sclk_gate: assert property (p_sclk_gate) else $error("shift while chip select high");

  property p_conv_runs;
    s.st == acp_pkg::ST_CONV && !sar.done |=> s.st == acp_pkg::ST_CONV;
  endproperty
  a_conv_runs: assert property (p_conv_runs) else $error("conversion left early");

  property p_pd_blocks;
    s.st == acp_pkg::ST_PD && s.filt[acp_pkg::SI_PD] |=> !s.start && s.lowpwr;
  endproperty
  a_pd_blocks: assert property (p_pd_blocks) else $error("start taken in power-down");

  property p_edge_start;
    s.st == acp_pkg::ST_WAIT && !s.filt[acp_pkg::SI_PD] && s.cnv_prev && !s.filt[acp_pkg::SI_CNV]
      |=> s.start && s.hold ##1 !s.start && s.busy;
  endproperty
  a_edge_start: assert property (p_edge_start) else $error("falling edge did not start");

  property p_low_start;
    s.st == acp_pkg::ST_ACQ && s.acq_cnt == acp_pkg::ACQ_LAST && !s.filt[acp_pkg::SI_PD]
      && !s.filt[acp_pkg::SI_CNV] |=> s.busy && s.hold && s.st == acp_pkg::ST_CONV;
  endproperty
  a_low_start: assert property (p_low_start) else $error("low convert-start did not start");

  property p_refbuf;
    $changed(s.filt[acp_pkg::SI_REF_BUFFER_DISABLE]) |=> s.refbuf == !$past(s.filt[acp_pkg::SI_REF_BUFFER_DISABLE]);
  endproperty
  a_refbuf: assert property (p_refbuf) else $error("reference buffer not enabled");

  property p_p18_data;
    mode == acp_pkg::MODE_P18 && rd_en |=> s.dout == $past(s.result) && s.doe == acp_pkg::OE_ALL;
  endproperty
  a_p18_data: assert property (p_p18_data) else $error("18-bit word not on bus");

  property p_ser_hi;
    mode == acp_pkg::MODE_SER |=> s.doe[17:14] == 4'hF;
  endproperty
  a_ser_hi: assert property (p_ser_hi) else $error("upper lines not outputs in serial mode");
endmodule

/* sim/acp_host_model.sv */
// Host side model: start and read strobes, select lines and comparator answer
`timescale 1ns/10ps
module acp_host_model (
  input wire logic mclk,
  input wire logic [17:0] dac_code,
  input wire logic [17:0] vin,
  output logic convert_start_n,
  output logic cs_n,
  output logic rd_n,
  output logic comp_in,
  output logic [17:0] data_drv
);
  logic [2:0] sel;
  logic sclk;
  logic [17:0] junk;
  initial begin
    convert_start_n = 1'b1;
    cs_n = 1'b1;
    rd_n = 1'b1;
    comp_in = 1'b0;
    sel = 3'h0;
    sclk = 1'b0;
    junk = 18'h15555;
  end
  // ==========================================================
  // Comparator and released lines
  always @(posedge mclk) begin
    comp_in <= (dac_code <= vin);
    junk <= ~junk;
  end
  // Lines nobody drives toggle so stale data never matches
  assign data_drv = {junk[17:12], sclk, junk[10:3], sel};
  // ==========================================================
  // Bus tasks
  task automatic cnv_level(input logic lvl);
    @(posedge mclk);
    convert_start_n <= lvl;
  endtask
  task automatic bus(input logic cs_on, input logic rd_on);
    @(posedge mclk);
    cs_n <= ~cs_on;
    rd_n <= ~rd_on;
  endtask
  task automatic set_sel(input logic [2:0] s);
    @(posedge mclk);
    sel <= s;
  endtask
  task automatic sclk_pulse();
    @(posedge mclk);
    sclk <= 1'b1;
    repeat (6) @(posedge mclk);
    sclk <= 1'b0;
    repeat (6) @(posedge mclk);
  endtask
endmodule

/* sim/acp_tb.sv */
// Self-checking testbench of the converter control and output port
`timescale 1ns/10ps
module tb;
  logic mclk, rst, power_down_in, ref_buffer_disable, iface_select_hi, iface_select_lo;
  logic convert_start_n, cs_n, rd_n, comp_in, busy, sample_hold, ref_buffer_en, low_power;
  logic [17:0] data_in, data_drv, data_out, data_oe, dac_code, vin;
  logic [17:0] c;
  logic cod;
  int err_total, n_checks, seed;
  int res_q[$];
  initial mclk = 1'b0;
  always #4 mclk = ~mclk;
  assign data_in = (data_oe & data_out) | (~data_oe & data_drv);
  acp_top dut_u (.mclk(mclk), .rst(rst), .convert_start_n(convert_start_n), .cs_n(cs_n), .rd_n(rd_n),
    .power_down_in(power_down_in), .ref_buffer_disable(ref_buffer_disable), .iface_select_hi(iface_select_hi),
    .iface_select_lo(iface_select_lo), .data_in(data_in), .comp_in(comp_in), .data_out(data_out),
    .data_oe(data_oe), .busy(busy), .sample_hold(sample_hold), .ref_buffer_en(ref_buffer_en),
    .low_power(low_power), .dac_code(dac_code));
  acp_host_model host_u (.mclk(mclk), .dac_code(dac_code), .vin(vin), .convert_start_n(convert_start_n),
    .cs_n(cs_n), .rd_n(rd_n), .comp_in(comp_in), .data_drv(data_drv));
  // ==========================================================
  // Reference model and compares
  function automatic logic [17:0] coded(input int r, input logic cd);
    coded = 18'(r) ^ (cd ? 18'h00000 : 18'h20000);
  endfunction
  function automatic logic [35:0] port_exp(input int m, input int r, input logic [2:0] s);
    logic [17:0] k;
    k = coded(r, s[0]);
    case (m)
      0: port_exp = {18'h3FFFF, 18'(r)};
      1: port_exp = {18'h3FFFC, (s[1] ? {14'h0000, k[1:0]} : k[17:2]), 2'h0};
      default: port_exp = {18'h3FC00, (s[1] ? {6'h00, k[1:0]} : (s[2] ? k[9:2] : k[17:10])), 10'h000};
    endcase
  endfunction
  task automatic cmp(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input int lo, input int hi, input int got);
    n_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Stimulus tasks
  task automatic set_mode(input int m);
    @(posedge mclk);
    {iface_select_hi, iface_select_lo} <= 2'(m);
  endtask
  task automatic run_conv(input logic hold, input logic pd);
    int n;
    n = 0;
    @(posedge mclk);
    vin <= 18'($random(seed));
    if (!hold) begin
      repeat (200) @(negedge mclk);
      cmp("busy idle", 18'h0, 18'(busy));
    end
    host_u.cnv_level(1'b0);
    while (busy !== 1'b1 && n < 1200) begin
      @(negedge mclk);
      n++;
    end
    if (hold) rng("start delay", acp_pkg::ACQ_CYC - 2, acp_pkg::ACQ_CYC + 8, n);
    else rng("start delay", 2, 8, n);
    host_u.cnv_level(1'b1);
    if (pd) power_down_in <= 1'b1;
    cmp("hold", 18'h1, 18'(sample_hold));
    n = 0;
    while (busy === 1'b1 && n < 1200) begin
      @(negedge mclk);
      n++;
    end
    rng("busy length", 18 * acp_pkg::STEP_CYC - 2, 18 * acp_pkg::STEP_CYC + 6, n);
    cmp("hold end", 18'h0, 18'(sample_hold));
    res_q.push_back(vin);
  endtask
  task automatic rd_chk(input int m, input logic [2:0] s);
    logic [35:0] e;
    host_u.set_sel(s);
    host_u.bus(1'b1, 1'b1);
    repeat (7) @(negedge mclk);
    e = port_exp(m, res_q[$], s);
    cmp("data_oe", e[35:18], data_oe);
    cmp("data_out", e[17:0], data_out & data_oe);
    host_u.bus(1'b1, 1'b0);
    repeat (7) @(negedge mclk);
    cmp("data_oe off", 18'h0, data_oe);
    host_u.bus(1'b0, 1'b0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hE4C3CBF5;
    rst = 1'b1;
    power_down_in = 1'b0;
    ref_buffer_disable = 1'($random(seed));
    {iface_select_hi, iface_select_lo} = 2'($random(seed));
    vin = 18'h00000;
    err_total = 0;
    n_checks = 0;
    repeat (16) @(negedge mclk);
    cmp("oe reset", 18'h0, data_oe);
    cmp("buffer reset", 18'h1, 18'(ref_buffer_en));
    @(posedge mclk) rst <= 1'b0;
    for (int m = 0; m < 3; m++) begin
      set_mode(m);
      run_conv(1'b0, 1'b0);
      run_conv(1'b1, 1'b0);
      for (int k = 0; k < 4; k++) rd_chk(m, {k[0], k[1], 1'($random(seed))});
    end
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk) ref_buffer_disable <= (k == 0) ? 1'($random(seed)) : ~ref_buffer_disable;
      repeat (8) @(negedge mclk);
      cmp("buffer", 18'(!ref_buffer_disable), 18'(ref_buffer_en));
    end
    set_mode(0);
    run_conv(1'b0, 1'b1);
    repeat (200) @(negedge mclk);
    cmp("low power", 18'h1, 18'(low_power));
    host_u.cnv_level(1'b0);
    repeat (20) @(negedge mclk);
    cmp("start refused", 18'h0, 18'(busy));
    host_u.cnv_level(1'b1);
    rd_chk(0, 3'h0);
    @(posedge mclk) power_down_in <= 1'b0;
    repeat (10) @(negedge mclk);
    cmp("awake", 18'h0, 18'(low_power));
    repeat (200) @(negedge mclk);
    host_u.cnv_level(1'b0);
    repeat (100) @(negedge mclk);
    @(posedge mclk) rst <= 1'b1;
    host_u.cnv_level(1'b1);
    @(negedge mclk);
    cmp("abort", 18'h0, 18'(busy));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    run_conv(1'b0, 1'b0);
    rd_chk(0, 3'h0);
    set_mode(3);
    cod = 1'($random(seed));
    host_u.set_sel({2'h0, cod});
    run_conv(1'b0, 1'b0);
    repeat (8) @(negedge mclk);
    cmp("serial idle oe", acp_pkg::OE_SER_FIX, data_oe);
    host_u.bus(1'b0, 1'b1);
    host_u.sclk_pulse();
    host_u.bus(1'b1, 1'b1);
    repeat (7) @(negedge mclk);
    cmp("serial oe", acp_pkg::OE_SER_FIX | acp_pkg::OE_SER_RD, data_oe);
    cmp("serial frame", 18'h01000, data_out & 18'h3F800);
    c = coded(res_q[$], cod);
    for (int i = 17; i >= 0; i--) begin
      @(negedge mclk);
      cmp("serial bit", 18'(c[i]), 18'(data_out[10]));
      host_u.sclk_pulse();
    end
    host_u.bus(1'b0, 1'b0);
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    end_sim();
  end
endmodule
